// [hdl/dss_pkg.sv]
// Package for the drive start/stop input mode logic: modes, states, timing
package dss_pkg;

  localparam int MODE_W = 4;

  typedef enum logic [3:0] {
    DSS_MODE_THREE_WIRE = 4'h0,
    DSS_MODE_TWO_WIRE   = 4'h1,
    DSS_MODE_KEYPAD     = 4'h2,
    DSS_MODE_MOMENTARY  = 4'h3,
    DSS_MODE_RAMP_SEL   = 4'h4,
    DSS_MODE_ENABLE     = 4'h5,
    DSS_MODE_SRC_SEL    = 4'h6,
    DSS_MODE_FREQ_SEL   = 4'h7,
    DSS_MODE_PRESET     = 4'h8,
    DSS_MODE_PI         = 4'h9
  } dss_mode_e;

  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] MODE_LAST  = 4'h9;

  // Run state machine
  typedef enum logic [1:0] {
    DSS_ST_IDLE  = 2'b00,
    DSS_ST_RUN   = 2'b01,
    DSS_ST_ARMED = 2'b10
  } dss_state_e;

  // Stop kind presented with the run flag
  typedef enum logic [1:0] {
    DSS_STOP_NONE  = 2'b00,
    DSS_STOP_MODE  = 2'b01,
    DSS_STOP_COAST = 2'b10
  } dss_stop_e;

  // Discrete control inputs, all active high (stop is active when its contact opens)
  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic start;
    logic stop;
    logic term8;
  } dss_pins_s;

  localparam int PINS_W = 5;

  // Keypad or communication port commands, one-cycle pulses except reverse
  typedef struct packed {
    logic start;
    logic stop;
    logic reverse;
  } dss_port_s;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

endpackage : dss_pkg

// [hdl/dss_sync.sv]
// Two-stage synchroniser and edge detector for the discrete control inputs
`timescale 1ns/1ps
`default_nettype none
module dss_sync (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire dss_pkg::dss_pins_s       pins_in,
  output var  dss_pkg::dss_pins_s       pins_sync,
  output var  dss_pkg::dss_pins_s       pins_rise
);

  typedef struct packed {
    dss_pkg::dss_pins_s s1;
    dss_pkg::dss_pins_s s2;
    dss_pkg::dss_pins_s s3;
  } dss_sync_s;

  dss_sync_s st_reg;
  dss_sync_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pins_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Edges look only at the second and third stages
  assign pins_sync = st_reg.s2;
  assign pins_rise = st_reg.s2 & ~st_reg.s3;

endmodule : dss_sync
`default_nettype wire

// [hdl/dss_mode_dec.sv]
// Decoder of the input-mode setting into control permissions
`timescale 1ns/1ps
`default_nettype none
module dss_mode_dec (
  input  wire logic [3:0] mode,
  input  wire logic       legacy_fw,
  output logic            mode_valid,
  output logic            two_wire,
  output logic            level_run,
  output logic            from_port,
  output logic            serial_ok,
  output logic            pi_ok
);

  always_comb begin
    mode_valid = (mode <= dss_pkg::MODE_LAST);
    two_wire   = 1'b0;
    level_run  = 1'b0;
    from_port  = 1'b0;
    serial_ok  = 1'b0;
    pi_ok      = 1'b0;
    case (mode)
      dss_pkg::DSS_MODE_THREE_WIRE: begin
        pi_ok = !legacy_fw;
      end
      dss_pkg::DSS_MODE_KEYPAD: begin
        from_port = 1'b1;
        serial_ok = 1'b1;
        pi_ok     = !legacy_fw;
      end
      dss_pkg::DSS_MODE_MOMENTARY: begin
        level_run = 1'b1;
        pi_ok     = !legacy_fw;
      end
      dss_pkg::DSS_MODE_TWO_WIRE,
      dss_pkg::DSS_MODE_RAMP_SEL,
      dss_pkg::DSS_MODE_ENABLE,
      dss_pkg::DSS_MODE_FREQ_SEL: begin
        two_wire = 1'b1;
        pi_ok    = !legacy_fw;
      end
      dss_pkg::DSS_MODE_SRC_SEL: begin
        two_wire  = 1'b1;
        serial_ok = 1'b1;
        pi_ok     = !legacy_fw;
      end
      dss_pkg::DSS_MODE_PRESET: begin
        two_wire = 1'b1;
        pi_ok    = 1'b0;
      end
      dss_pkg::DSS_MODE_PI: begin
        two_wire = 1'b1;
        pi_ok    = 1'b1;
      end
      default: begin
        two_wire = 1'b0;
      end
    endcase
    // Factory mode listens to the terminals alone, whatever the firmware
    if (!legacy_fw && mode != dss_pkg::DSS_MODE_THREE_WIRE) begin
      serial_ok = 1'b1;
    end
  end

endmodule : dss_mode_dec
`default_nettype wire

// [hdl/dss_ctrl.sv]
// Start, stop and direction command logic selected by the input-mode setting
`timescale 1ns/1ps
`default_nettype none
module dss_ctrl (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire dss_pkg::dss_pins_s pins_in,
  input  wire dss_pkg::dss_port_s port_cmd,
  input  wire dss_pkg::dss_port_s serial_cmd,
  input  wire logic [3:0]         mode_wdata,
  input  wire logic               mode_we,
  input  wire logic               legacy_fw,
  input  wire logic               pi_request,
  input  wire logic [1:0]         stop_mode_setting,
  output logic                    run_req,
  output logic                    run_dir_rev,
  output logic [1:0]              stop_kind,
  output logic [1:0]              stop_mode_out,
  output logic                    ramp_set2,
  output logic                    pi_active,
  output logic [3:0]              input_mode_setting,
  output logic                    mode_reject
);

  typedef struct packed {
    logic [3:0]          mode;
    dss_pkg::dss_state_e state;
    logic                dir_rev;
    logic [1:0]          stop_kind;
    logic [1:0]          stop_mode;
    logic                ramp2;
    logic                pi;
    logic                reject;
  } dss_ctrl_s;

  dss_ctrl_s          st_reg;
  dss_ctrl_s          st_next;
  dss_pkg::dss_pins_s pins_sync;
  dss_pkg::dss_pins_s pins_rise;
  logic               mode_valid;
  logic               wr_valid;
  logic               two_wire;
  logic               level_run;
  logic               from_port;
  logic               serial_ok;
  logic               pi_ok;

  dss_sync u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pins_in   (pins_in),
    .pins_sync (pins_sync),
    .pins_rise (pins_rise)
  );

  dss_mode_dec u_dec (
    .mode       (st_reg.mode),
    .legacy_fw  (legacy_fw),
    .mode_valid (mode_valid),
    .two_wire   (two_wire),
    .level_run  (level_run),
    .from_port  (from_port),
    .serial_ok  (serial_ok),
    .pi_ok      (pi_ok)
  );

  assign wr_valid = (mode_wdata <= dss_pkg::MODE_LAST);

  always_comb begin
    logic stop_now;
    logic coast;
    logic start_fwd;
    logic start_rev;
    logic held;
    logic ser_start;
    logic ser_stop;
    stop_now  = 1'b0;
    coast     = 1'b0;
    start_fwd = 1'b0;
    start_rev = 1'b0;
    held      = pins_sync.run_fwd | pins_sync.run_rev;
    ser_start = serial_ok & serial_cmd.start;
    ser_stop  = serial_ok & serial_cmd.stop;
    st_next   = st_reg;
    st_next.reject = 1'b0;

    // Mode changes only while stopped so a live run never changes its rules
    if (mode_we) begin
      if (wr_valid && st_reg.state != dss_pkg::DSS_ST_RUN) begin
        st_next.mode = mode_wdata;
      end else begin
        st_next.reject = 1'b1;
      end
    end

    if (from_port) begin
      // Terminal start and reverse ignored; terminal stop still acts
      stop_now  = pins_sync.stop | port_cmd.stop | ser_stop;
      start_fwd = (port_cmd.start & ~port_cmd.reverse) | (ser_start & ~serial_cmd.reverse);
      start_rev = (port_cmd.start & port_cmd.reverse) | (ser_start & serial_cmd.reverse);
    end else if (level_run) begin
      stop_now  = pins_sync.stop | ser_stop;
      start_fwd = pins_sync.run_fwd;
      start_rev = pins_sync.run_rev & ~pins_sync.run_fwd;
    end else if (two_wire) begin
      stop_now  = pins_sync.stop | ser_stop;
      if (st_reg.mode == dss_pkg::DSS_MODE_ENABLE && !pins_sync.term8) begin
        stop_now = 1'b1;
        coast    = 1'b1;
      end
      if (st_reg.state == dss_pkg::DSS_ST_RUN && !held) begin
        stop_now = 1'b1;
      end
      // Only a fresh edge starts; a held input after a stop is ignored
      start_fwd = pins_rise.run_fwd | (ser_start & ~serial_cmd.reverse);
      start_rev = pins_rise.run_rev | (ser_start & serial_cmd.reverse);
    end else if (mode_valid) begin
      // Three-wire: start pulse latches run, direction from run reverse level
      stop_now  = pins_sync.stop | ser_stop;
      start_fwd = pins_rise.start & ~pins_sync.run_rev;
      start_rev = pins_rise.start & pins_sync.run_rev;
      start_fwd = start_fwd | (pins_rise.run_fwd & ~pins_sync.run_rev);
      start_rev = start_rev | pins_rise.run_rev;
    end else begin
      stop_now = 1'b1;
    end

    // Ramp set follows terminal 8 only in ramp-select mode
    st_next.ramp2 = (st_reg.mode == dss_pkg::DSS_MODE_RAMP_SEL) & pins_sync.term8;
    st_next.pi    = pi_ok & pi_request;

    case (st_reg.state)
      dss_pkg::DSS_ST_IDLE: begin
        if (!stop_now && (start_fwd || start_rev)) begin
          st_next.state     = dss_pkg::DSS_ST_RUN;
          st_next.dir_rev   = start_rev;
          st_next.stop_kind = dss_pkg::DSS_STOP_NONE;
        end
      end
      dss_pkg::DSS_ST_RUN: begin
        if (stop_now) begin
          st_next.state     = dss_pkg::DSS_ST_IDLE;
          st_next.dir_rev   = 1'b0;
          st_next.stop_kind = coast ? dss_pkg::DSS_STOP_COAST : dss_pkg::DSS_STOP_MODE;
          st_next.stop_mode = stop_mode_setting;
        end else if (level_run || two_wire) begin
          // Direction tracks the held input in level mode; in two-wire modes forward follows the level, reverse needs a fresh edge
          if (start_rev && !pins_sync.run_fwd) begin
            st_next.dir_rev = 1'b1;
          end else if (pins_sync.run_fwd) begin
            st_next.dir_rev = 1'b0;
          end
        end else if (from_port && (port_cmd.start || ser_start)) begin
          st_next.dir_rev = start_rev;
        end
      end
      default: begin
        st_next.state = dss_pkg::DSS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg.mode      <= dss_pkg::MODE_RESET;
      st_reg.state     <= dss_pkg::DSS_ST_IDLE;
      st_reg.dir_rev   <= 1'b0;
      st_reg.stop_kind <= dss_pkg::DSS_STOP_NONE;
      st_reg.stop_mode <= 2'h0;
      st_reg.ramp2     <= 1'b0;
      st_reg.pi        <= 1'b0;
      st_reg.reject    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign run_req            = (st_reg.state == dss_pkg::DSS_ST_RUN);
  assign run_dir_rev        = st_reg.dir_rev;
  assign stop_kind          = st_reg.stop_kind;
  assign stop_mode_out      = st_reg.stop_mode;
  assign ramp_set2          = st_reg.ramp2;
  assign pi_active          = st_reg.pi;
  assign input_mode_setting = st_reg.mode;
  assign mode_reject        = st_reg.reject;

endmodule : dss_ctrl
`default_nettype wire

// [test/dss_ctrl_properties.sv]
// Concurrent checks on the start/stop command block ports
`timescale 1ns/1ps
`default_nettype none
module dss_ctrl_chk (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire dss_pkg::dss_pins_s pins_in,
  input wire dss_pkg::dss_port_s port_cmd,
  input wire dss_pkg::dss_port_s serial_cmd,
  input wire logic [3:0]         mode_wdata,
  input wire logic               mode_we,
  input wire logic               legacy_fw,
  input wire logic               pi_request,
  input wire logic               run_req,
  input wire logic               run_dir_rev,
  input wire logic [1:0]         stop_kind,
  input wire logic               ramp_set2,
  input wire logic               pi_active,
  input wire logic [3:0]         input_mode_setting,
  input wire logic               mode_reject
);
  wire two_w = input_mode_setting == 4'h1 || input_mode_setting inside {[4'h4:4'h9]};
  wire m3 = input_mode_setting == 4'h3;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Four samples cover the two synchroniser stages
  sequence released_s;
    (two_w && !pins_in.run_fwd && !pins_in.run_rev && !serial_cmd.start) [*4];
  endsequence
  sequence held_stop_off_s;
    (m3 && !pins_in.stop && !port_cmd.stop && !serial_cmd.stop) [*4] ##0 run_req;
  endsequence
  AST_MODE_RANGE: assert property (input_mode_setting <= 4'h9)
    else $error("mode outside 0 to 9");
  AST_MODE_WRITE: assert property (mode_we && mode_wdata <= 4'h9 && !run_req
    |=> input_mode_setting == $past(mode_wdata) && !mode_reject)
    else $error("mode write not taken");
  AST_REJECT: assert property (mode_we && (mode_wdata > 4'h9 || run_req)
    |=> mode_reject && $stable(input_mode_setting))
    else $error("bad mode write not refused");
  AST_STOP_CLEARS: assert property ($fell(run_req) |-> !run_dir_rev && stop_kind != 2'h0)
    else $error("stop left direction or kind");
  AST_TERM_IGNORED: assert property (input_mode_setting == 4'h2 && !run_req
    && port_cmd.start == 1'b0 && serial_cmd.start == 1'b0 |=> !run_req)
    else $error("terminal started in port mode");
  AST_TWO_WIRE: assert property (released_s |=> !run_req)
    else $error("run kept after release");
  AST_HOLD_M3: assert property (held_stop_off_s |=> run_req)
    else $error("momentary mode stopped without stop");
  AST_PI_LEGACY: assert property (legacy_fw && !mode_we && input_mode_setting != 4'h9
    |=> !pi_active)
    else $error("legacy PI outside mode 9");
  AST_PI_NEW: assert property (!legacy_fw && !mode_we
    |=> pi_active == ($past(pi_request) && $past(input_mode_setting) != 4'h8))
    else $error("PI permission wrong");
  AST_RAMP: assert property (input_mode_setting != 4'h4 && !mode_we |=> !ramp_set2)
    else $error("second ramp set outside mode 4");
endmodule : dss_ctrl_chk
`default_nettype wire

// [test/dss_switches.sv]
// Operator contacts on the control terminal block
`timescale 1ns/1ps
`default_nettype none
module dss_switches (
  input  wire logic         fwd,
  input  wire logic         rev,
  input  wire logic         start,
  input  wire logic         stop_open,
  input  wire logic         enable,
  output var  dss_pkg::dss_pins_s pins
);
  // Interlock, the device state with both runs closed is undefined
  always_comb pins = '{run_fwd: fwd, run_rev: rev & ~fwd, start: start,
                       stop: stop_open, term8: enable};
endmodule : dss_switches
`default_nettype wire

// [test/dss_ctrl_tb.sv]
// Self-checking bench of the start/stop command block
`timescale 1ns/1ps
`default_nettype none
bind dss_ctrl dss_ctrl_chk dss_ctrl_chk_i (.core_clk(core_clk), .rst_n(rst_n),
  .pins_in(pins_in), .port_cmd(port_cmd), .serial_cmd(serial_cmd), .mode_wdata(mode_wdata),
  .mode_we(mode_we), .legacy_fw(legacy_fw), .pi_request(pi_request), .run_req(run_req),
  .run_dir_rev(run_dir_rev), .stop_kind(stop_kind), .ramp_set2(ramp_set2),
  .pi_active(pi_active), .input_mode_setting(input_mode_setting), .mode_reject(mode_reject));
module dss_ctrl_tb;
  logic core_clk = 1'b0;
  logic rst_n, fwd, rev, st, sp, en, mode_we, legacy_fw, pi_request;
  logic run_req, run_dir_rev, ramp_set2, pi_active, mode_reject;
  logic [1:0] stop_mode_setting, stop_kind, stop_mode_out;
  logic [3:0] mode_wdata, input_mode_setting;
  dss_pkg::dss_pins_s pins_in;
  dss_pkg::dss_port_s port_cmd, serial_cmd;
  int mismatches = 0;
  int checked = 0;
  always #12.5 core_clk = ~core_clk;
  dss_switches dss_switches_i (.fwd(fwd), .rev(rev), .start(st), .stop_open(sp),
    .enable(en), .pins(pins_in));
  dss_ctrl dss_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .pins_in(pins_in),
    .port_cmd(port_cmd), .serial_cmd(serial_cmd), .mode_wdata(mode_wdata),
    .mode_we(mode_we), .legacy_fw(legacy_fw), .pi_request(pi_request),
    .stop_mode_setting(stop_mode_setting), .run_req(run_req), .run_dir_rev(run_dir_rev),
    .stop_kind(stop_kind), .stop_mode_out(stop_mode_out), .ramp_set2(ramp_set2),
    .pi_active(pi_active), .input_mode_setting(input_mode_setting),
    .mode_reject(mode_reject));
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // Bounded wait, three edges of latency plus margin
  task automatic await_run(input logic e);
    for (int i = 0; i < 8; i++) begin
      if (run_req === e) return;
      tick(1);
    end
    chk(run_req, e);
    final_report();
  endtask : await_run
  task automatic sw(input logic [4:0] v);
    @(posedge core_clk);
    {fwd, rev, st, sp, en} <= v;
  endtask : sw
  task automatic set_mode(input logic [3:0] v, input logic rej);
    @(posedge core_clk);
    mode_wdata <= v;
    mode_we <= 1'b1;
    @(posedge core_clk);
    mode_we <= 1'b0;
    #1;
    chk(mode_reject, rej);
  endtask : set_mode
  task automatic pulse(input logic ser, input dss_pkg::dss_port_s v);
    @(posedge core_clk);
    if (ser) serial_cmd <= v;
    else port_cmd <= v;
    @(posedge core_clk);
    port_cmd <= '0;
    serial_cmd <= '0;
    #1;
  endtask : pulse
  initial begin
    {fwd, rev, st, sp, en} = '0;
    port_cmd = '0;
    serial_cmd = '0;
    mode_wdata = '0;
    mode_we = 1'b0;
    legacy_fw = 1'b0;
    pi_request = 1'b0;
    stop_mode_setting = 2'h2;
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(1);
    chk(input_mode_setting, 4'h0);
    chk(run_req, 1'b0);
    pulse(1'b0, 3'b100);
    tick(5);
    chk(run_req, 1'b0);
    sw(5'b01100);
    sw(5'b01000);
    await_run(1'b1);
    chk(run_dir_rev, 1'b1);
    set_mode(4'h1, 1'b1);
    chk(input_mode_setting, 4'h0);
    sw(5'b01010);
    sw(5'b00000);
    await_run(1'b0);
    chk(stop_kind, 2'h1);
    chk(stop_mode_out, 2'h2);
    sw(5'b00100);
    await_run(1'b1);
    sw(5'b00110);
    sw(5'b00100);
    await_run(1'b0);
    tick(6);
    chk(run_req, 1'b0);
    sw(5'b00000);
    set_mode(4'ha, 1'b1);
    for (int m = 0; m < 10; m++) begin
      set_mode(m[3:0], 1'b0);
      chk(input_mode_setting, m[3:0]);
    end
    @(posedge core_clk) pi_request <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      for (int m = 0; m < 10; m++) begin
        @(posedge core_clk) legacy_fw <= f[0];
        set_mode(m[3:0], 1'b0);
        tick(2);
        chk(pi_active, f ? (m == 9) : (m != 8));
      end
    end
    @(posedge core_clk) pi_request <= 1'b0;
    stop_mode_setting <= 2'h1;
    set_mode(4'h1, 1'b0);
    sw(5'b10000);
    await_run(1'b1);
    chk(run_dir_rev, 1'b0);
    sw(5'b00000);
    await_run(1'b0);
    chk(stop_kind, 2'h1);
    chk(stop_mode_out, 2'h1);
    sw(5'b01000);
    await_run(1'b1);
    chk(run_dir_rev, 1'b1);
    sw(5'b00000);
    await_run(1'b0);
    set_mode(4'h3, 1'b0);
    sw(5'b10000);
    await_run(1'b1);
    sw(5'b10010);
    await_run(1'b0);
    sw(5'b10000);
    await_run(1'b1);
    sw(5'b00000);
    tick(6);
    chk(run_req, 1'b1);
    sw(5'b00010);
    await_run(1'b0);
    sw(5'b00000);
    set_mode(4'h2, 1'b0);
    sw(5'b10100);
    tick(6);
    chk(run_req, 1'b0);
    sw(5'b00000);
    pulse(1'b0, 3'b101);
    chk(run_req, 1'b1);
    chk(run_dir_rev, 1'b1);
    pulse(1'b0, 3'b010);
    chk(run_req, 1'b0);
    @(posedge core_clk) legacy_fw <= 1'b1;
    pulse(1'b1, 3'b100);
    chk(run_req, 1'b1);
    pulse(1'b1, 3'b010);
    set_mode(4'h0, 1'b0);
    pulse(1'b1, 3'b100);
    tick(1);
    chk(run_req, 1'b0);
    @(posedge core_clk) legacy_fw <= 1'b0;
    pulse(1'b1, 3'b100);
    tick(1);
    chk(run_req, 1'b0);
    set_mode(4'h5, 1'b0);
    sw(5'b10001);
    await_run(1'b1);
    sw(5'b10000);
    await_run(1'b0);
    chk(stop_kind, 2'h2);
    sw(5'b00000);
    set_mode(4'h4, 1'b0);
    sw(5'b00001);
    tick(5);
    chk(ramp_set2, 1'b1);
    sw(5'b00000);
    tick(5);
    chk(ramp_set2, 1'b0);
    final_report();
  end
endmodule : dss_ctrl_tb
`default_nettype wire
